// file: src/fdco_pkg.sv
// constants and types for the floppy drive control output block
package fdco_pkg;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_DIGITAL_OUTPUT = 8'h00;
  localparam logic [7:0] OFS_FUNCTION_ENABLE = 8'h04;
  localparam logic [7:0] OFS_FUNCTION_CONTROL = 8'h08;
  localparam logic [7:0] OFS_CONFIG_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_DATA_RATE_SELECT = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // values after reset
  localparam logic [7:0] RST_DIGITAL_OUTPUT = 8'h00;
  localparam logic [7:0] RST_FUNCTION_ENABLE = 8'h08;
  localparam logic [7:0] RST_FUNCTION_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h20;
  localparam int unsigned RST_DMA_CH = 2;
  // field positions
  localparam int unsigned DIGOUT_SEL_LSB = 0;
  localparam int unsigned DIGOUT_DMA_EN_BIT = 3;
  localparam int unsigned DIGOUT_MOTOR_LSB = 4;
  localparam int unsigned FNEN_FDC_EN_BIT = 3;
  localparam int unsigned FNEN_ENCODED_BIT = 4;
  localparam int unsigned FNCTL_SWAP_BIT = 4;
  localparam int unsigned MODE_FORCE_EN_BIT = 0;
  localparam int unsigned MODE_FORCE_LVL_BIT = 1;
  localparam int unsigned MODE_PPM_BIT = 2;
  localparam int unsigned MODE_PIN_FLAG_BIT = 3;
  localparam int unsigned MODE_DMA_CH_LSB = 4;
  localparam int unsigned MODE_NO_DMA_BIT = 6;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // data rate codes
  typedef enum logic [1:0] {
    RATE_500K = 2'h0,
    RATE_300K = 2'h1,
    RATE_250K = 2'h2,
    RATE_1M = 2'h3
  } fdco_rate_t;
  localparam fdco_rate_t RST_RATE = RATE_250K;
  // bus handshake states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_RESP = 1'b1
  } fdco_bus_state_t;
  // status register layout, high bits first
  typedef struct packed {
    logic ack_active;
    logic [1:0] drive_select_n;
    logic head_dir_n;
    logic density;
    fdco_rate_t rate;
  } fdco_status_t;
endpackage : fdco_pkg

// file: src/fdco_ds_if.sv
// carrier between the register logic and the drive select decoder
`timescale 1ns/1ps
interface fdco_ds_if #(parameter int unsigned NUM_DRIVES = 4);
  logic [1:0] sel;
  logic [NUM_DRIVES-1:0] motor;
  logic encoded;
  logic swap;
  logic [1:0] ds_n;
  modport ctl (output sel, output motor, output encoded, output swap, input ds_n);
  modport dec (input sel, input motor, input encoded, input swap, output ds_n);
endinterface : fdco_ds_if

// file: src/fdco_drive_decode.sv
// drive select decoder with motor gating, swap and encoded mode
`timescale 1ns/1ps
module fdco_drive_decode #(
  parameter int unsigned NUM_DRIVES = 4
) (
  fdco_ds_if.dec ds
);
  import fdco_pkg::*;
  logic [NUM_DRIVES-1:0] hit;
  logic [1:0] phys_sel;
  logic any_hit;

  // logical drive hit, gated by its own motor bit
  for (genvar i = 0; i < NUM_DRIVES; i++) begin : g_hit
    assign hit[i] = (ds.sel == 2'(i)) && ds.motor[i];
  end

  // exchange of drives zero and one
  assign phys_sel = (ds.swap && !ds.sel[1]) ? {1'b0, ~ds.sel[0]} : ds.sel;
  assign any_hit = |hit;

  // pin levels: one-hot low, or encoded selected drive
  always_comb begin
    if (ds.encoded) begin
      ds.ds_n = any_hit ? ~phys_sel : 2'h3;
    end else if (ds.swap) begin
      ds.ds_n = {~hit[0], ~hit[1]};
    end else begin
      ds.ds_n = {~hit[1], ~hit[0]};
    end
  end
endmodule : fdco_drive_decode

// file: src/fdco_top.sv
// floppy drive control outputs with axi4-lite register slave
`timescale 1ns/1ps
module fdco_top #(
  parameter int unsigned NUM_DMA_CH = 4,
  parameter int unsigned NUM_DRIVES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [fdco_pkg::ADDR_W-1:0] s_axil_awaddr,
  input wire logic [2:0] s_axil_awprot,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [fdco_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic [2:0] s_axil_arprot,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic ident,
  input wire logic seek_active,
  input wire logic seek_step_in,
  input wire logic rw_active,
  input wire logic fdc_dma_req,
  input wire logic [7:0] fdc_rd_byte,
  output logic [7:0] dma_wr_byte,
  output logic dma_wr_strobe,
  output logic dma_rd_strobe,
  input wire logic [NUM_DMA_CH-1:0] dma_ack_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic [NUM_DMA_CH-1:0] dma_request,
  output logic [NUM_DMA_CH-1:0] dma_request_oe,
  output logic density_select,
  output logic head_dir_n,
  output logic drive_select_0_n,
  output logic drive_select_1_n,
  output logic density_select_ppm,
  output logic head_dir_ppm_n
);
  import fdco_pkg::*;
  // refuse shapes the logic cannot serve
  if (NUM_DMA_CH < 3 || NUM_DMA_CH > 4) begin : g_bad_ch
    $error("NUM_DMA_CH must be 3 or 4");
  end
  if (NUM_DRIVES != 4) begin : g_bad_drv
    $error("NUM_DRIVES must be 4");
  end

  localparam logic [NUM_DMA_CH-1:0] RST_DMA_OE = NUM_DMA_CH'(1 << RST_DMA_CH);
  fdco_ds_if #(.NUM_DRIVES(NUM_DRIVES)) ds_if ();
  // bus state
  fdco_bus_state_t wstate, next_wstate, rstate, next_rstate;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic [7:0] wbyte_q, next_wbyte_q;
  logic wlane_q, next_wlane_q;
  logic next_awready, next_wready, next_arready;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write;
  // register state
  logic [7:0] digital_output_reg, next_digital_output_reg;
  logic [7:0] function_enable_reg, next_function_enable_reg;
  logic [7:0] function_control_reg, next_function_control_reg;
  logic [7:0] mode_reg, next_mode_reg;
  fdco_rate_t rate, next_rate;
  // drive outputs
  logic next_density, next_dir_n, next_density_ppm, next_dir_ppm_n;
  logic high_density, auto_density, ppm_on;
  // dma path
  logic [1:0] dma_ch;
  logic dma_path_ok;
  logic [NUM_DMA_CH-1:0] ack_sel, next_req, next_req_oe;
  logic ack_active, ack_active_q;
  logic rd_n_q, wr_n_q;
  logic next_host_oe, next_wr_strobe, next_rd_strobe;
  logic [7:0] next_host_out, next_wr_byte;
  fdco_status_t status;
  // offsets that answer okay on write
  function automatic logic wr_mapped(input logic [ADDR_W-1:0] a);
    wr_mapped = (a == OFS_DIGITAL_OUTPUT) || (a == OFS_FUNCTION_ENABLE) ||
                (a == OFS_FUNCTION_CONTROL) || (a == OFS_CONFIG_CONTROL) ||
                (a == OFS_DATA_RATE_SELECT) || (a == OFS_MODE) || (a == OFS_STATUS);
  endfunction : wr_mapped
  function automatic logic is_high(input fdco_rate_t r);
    is_high = (r == RATE_500K) || (r == RATE_1M);
  endfunction : is_high
  assign do_write = aw_held && w_held && (wstate == BUS_IDLE);
  // write channel: address and data taken in either order
  always_comb begin
    next_wstate = wstate;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wbyte_q = wbyte_q;
    next_wlane_q = wlane_q;
    next_bresp = s_axil_bresp;
    if (s_axil_awvalid && s_axil_awready) begin
      next_aw_held = 1'b1;
      next_awaddr_q = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      next_w_held = 1'b1;
      next_wbyte_q = s_axil_wdata[7:0];
      next_wlane_q = s_axil_wstrb[0];
    end
    unique case (wstate)
      BUS_IDLE: begin
        if (do_write) begin
          next_wstate = BUS_RESP;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_bresp = wr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      BUS_RESP: begin
        if (s_axil_bready) begin
          next_wstate = BUS_IDLE;
        end
      end
    endcase
    next_awready = !next_aw_held && (next_wstate == BUS_IDLE);
    next_wready = !next_w_held && (next_wstate == BUS_IDLE);
  end

  // status word of the block's own state
  assign status = '{ack_active: ack_active_q, drive_select_n: {drive_select_1_n, drive_select_0_n},
                    head_dir_n: head_dir_n, density: density_select, rate: rate};

  // read channel: one read at a time
  always_comb begin
    next_rstate = rstate;
    next_rdata = s_axil_rdata;
    next_rresp = s_axil_rresp;
    unique case (rstate)
      BUS_IDLE: begin
        if (s_axil_arvalid && s_axil_arready) begin
          next_rstate = BUS_RESP;
          next_rresp = RESP_OKAY;
          unique case (s_axil_araddr)
            OFS_DIGITAL_OUTPUT: next_rdata = {24'h0, digital_output_reg};
            OFS_FUNCTION_ENABLE: next_rdata = {24'h0, function_enable_reg};
            OFS_FUNCTION_CONTROL: next_rdata = {24'h0, function_control_reg};
            OFS_CONFIG_CONTROL, OFS_DATA_RATE_SELECT: next_rdata = {30'h0, rate};
            OFS_MODE: next_rdata = {24'h0, mode_reg};
            OFS_STATUS: next_rdata = {25'h0, status};
            default: begin
              next_rdata = 32'h0;
              next_rresp = RESP_SLVERR;
            end
          endcase
        end
      end
      BUS_RESP: begin
        if (s_axil_rready) begin
          next_rstate = BUS_IDLE;
        end
      end
    endcase
    next_arready = (next_rstate == BUS_IDLE);
  end

  // register writes; both rate registers feed one rate
  always_comb begin
    next_digital_output_reg = digital_output_reg;
    next_function_enable_reg = function_enable_reg;
    next_function_control_reg = function_control_reg;
    next_mode_reg = mode_reg;
    next_rate = rate;
    if (do_write && wlane_q) begin
      unique case (awaddr_q)
        OFS_DIGITAL_OUTPUT: next_digital_output_reg = wbyte_q;
        OFS_FUNCTION_ENABLE: next_function_enable_reg = wbyte_q;
        OFS_FUNCTION_CONTROL: next_function_control_reg = wbyte_q;
        OFS_CONFIG_CONTROL: next_rate = fdco_rate_t'(wbyte_q[1:0]);
        OFS_DATA_RATE_SELECT: next_rate = fdco_rate_t'(wbyte_q[1:0]);
        OFS_MODE: next_mode_reg = wbyte_q;
        default: next_rate = rate;
      endcase
    end
  end

  // density and direction, computed from next rate so both move together
  always_comb begin
    high_density = is_high(next_rate);
    auto_density = ident ? high_density : !high_density;
    next_density = next_mode_reg[MODE_FORCE_EN_BIT] ? next_mode_reg[MODE_FORCE_LVL_BIT] : auto_density;
    next_dir_n = head_dir_n;
    if (rw_active) begin
      next_dir_n = 1'b1;
    end else if (seek_active) begin
      next_dir_n = !seek_step_in;
    end
    ppm_on = next_mode_reg[MODE_PPM_BIT] && !next_mode_reg[MODE_PIN_FLAG_BIT];
    next_density_ppm = ppm_on ? next_density : 1'b0;
    next_dir_ppm_n = ppm_on ? next_dir_n : 1'b1;
  end

  // decoder inputs straight from the output, function enable and function control registers
  assign ds_if.sel = digital_output_reg[DIGOUT_SEL_LSB +: 2];
  assign ds_if.motor = digital_output_reg[DIGOUT_MOTOR_LSB +: NUM_DRIVES];
  assign ds_if.encoded = function_enable_reg[FNEN_ENCODED_BIT];
  assign ds_if.swap = function_control_reg[FNCTL_SWAP_BIT];

  fdco_drive_decode #(.NUM_DRIVES(NUM_DRIVES)) fdco_drive_decode_i (
    .ds(ds_if.dec)
  );

  // dma channel routing and acknowledge qualification
  assign dma_ch = mode_reg[MODE_DMA_CH_LSB +: 2];
  assign dma_path_ok = function_enable_reg[FNEN_FDC_EN_BIT] && !mode_reg[MODE_NO_DMA_BIT];
  for (genvar c = 0; c < NUM_DMA_CH; c++) begin : g_ch
    assign ack_sel[c] = !dma_ack_n[c] && dma_path_ok && (dma_ch == 2'(c));
    assign next_req_oe[c] = dma_path_ok && (dma_ch == 2'(c));
    assign next_req[c] = next_req_oe[c] && digital_output_reg[DIGOUT_DMA_EN_BIT] && fdc_dma_req;
  end
  assign ack_active = |ack_sel;

  // host data bus strobes, honoured only under acknowledge
  always_comb begin
    next_host_oe = ack_active && !rd_n;
    next_host_out = next_host_oe ? fdc_rd_byte : 8'h00;
    next_wr_strobe = ack_active && !wr_n && wr_n_q;
    next_rd_strobe = ack_active && rd_n && !rd_n_q;
    next_wr_byte = next_wr_strobe ? host_data_in : dma_wr_byte;
  end

  // all state registered here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= BUS_IDLE;
      rstate <= BUS_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axil_awready <= 1'b0;
      s_axil_wready <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= RESP_OKAY;
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b0;
      s_axil_rresp <= RESP_OKAY;
      s_axil_rdata <= 32'h0;
      digital_output_reg <= RST_DIGITAL_OUTPUT;
      function_enable_reg <= RST_FUNCTION_ENABLE;
      function_control_reg <= RST_FUNCTION_CONTROL;
      mode_reg <= RST_MODE;
      rate <= RST_RATE;
      density_select <= 1'b0;
      head_dir_n <= 1'b1;
      density_select_ppm <= 1'b0;
      head_dir_ppm_n <= 1'b1;
      drive_select_0_n <= 1'b1;
      drive_select_1_n <= 1'b1;
      dma_request <= '0;
      dma_request_oe <= RST_DMA_OE;
      ack_active_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      host_data_oe <= 1'b0;
      host_data_out <= 8'h00;
      dma_wr_strobe <= 1'b0;
      dma_rd_strobe <= 1'b0;
      dma_wr_byte <= 8'h00;
    end else begin
      wstate <= next_wstate;
      rstate <= next_rstate;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wbyte_q <= next_wbyte_q;
      wlane_q <= next_wlane_q;
      s_axil_awready <= next_awready;
      s_axil_wready <= next_wready;
      s_axil_bvalid <= (next_wstate == BUS_RESP);
      s_axil_bresp <= next_bresp;
      s_axil_arready <= next_arready;
      s_axil_rvalid <= (next_rstate == BUS_RESP);
      s_axil_rresp <= next_rresp;
      s_axil_rdata <= next_rdata;
      digital_output_reg <= next_digital_output_reg;
      function_enable_reg <= next_function_enable_reg;
      function_control_reg <= next_function_control_reg;
      mode_reg <= next_mode_reg;
      rate <= next_rate;
      density_select <= next_density;
      head_dir_n <= next_dir_n;
      density_select_ppm <= next_density_ppm;
      head_dir_ppm_n <= next_dir_ppm_n;
      drive_select_0_n <= ds_if.ds_n[0];
      drive_select_1_n <= ds_if.ds_n[1];
      dma_request <= next_req;
      dma_request_oe <= next_req_oe;
      ack_active_q <= ack_active;
      rd_n_q <= rd_n;
      wr_n_q <= wr_n;
      host_data_oe <= next_host_oe;
      host_data_out <= next_host_out;
      dma_wr_strobe <= next_wr_strobe;
      dma_rd_strobe <= next_rd_strobe;
      dma_wr_byte <= next_wr_byte;
    end
  end

  // density follows rate and ident polarity
  chk_density_high_ident: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && !mode_reg[MODE_FORCE_EN_BIT] && $past(ident)) |-> (density_select == is_high(rate)))
    else $error("density select wrong for rate with ident high");
  chk_density_low_ident: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && !mode_reg[MODE_FORCE_EN_BIT] && !$past(ident)) |-> (density_select != is_high(rate)))
    else $error("density select wrong for rate with ident low");
  chk_density_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && mode_reg[MODE_FORCE_EN_BIT]) |-> (density_select == mode_reg[MODE_FORCE_LVL_BIT]))
    else $error("forced density level not driven");
  chk_density_same_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && $changed(rate) && is_high(rate) != is_high($past(rate)) && $stable(ident) &&
     !mode_reg[MODE_FORCE_EN_BIT] && !$past(mode_reg[MODE_FORCE_EN_BIT])) |-> $changed(density_select))
    else $error("density select lagged the rate change");
  chk_ppm_copies: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_reg[MODE_PPM_BIT] && !mode_reg[MODE_PIN_FLAG_BIT]) |->
      (density_select_ppm == density_select && head_dir_ppm_n == head_dir_n))
    else $error("ppm copies differ from main pins");
  chk_dir_seek: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && $past(seek_active) && !$past(rw_active)) |-> (head_dir_n == !$past(seek_step_in)))
    else $error("direction does not follow seek step");
  chk_dir_rw_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(rw_active) |-> head_dir_n)
    else $error("direction active during read or write");
  chk_drive_plain: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && !$past(ds_if.encoded) && !$past(ds_if.swap)) |->
      (drive_select_0_n == !($past(ds_if.sel) == 2'h0 && $past(ds_if.motor[0])) &&
       drive_select_1_n == !($past(ds_if.sel) == 2'h1 && $past(ds_if.motor[1]))))
    else $error("plain drive select decode wrong");
  chk_drive_swap: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && !$past(ds_if.encoded) && $past(ds_if.swap)) |->
      (drive_select_0_n == !($past(ds_if.sel) == 2'h1 && $past(ds_if.motor[1]))))
    else $error("swapped drive select wrong");
  chk_drive_motor_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && $past(ds_if.motor) == '0) |-> (drive_select_0_n && drive_select_1_n))
    else $error("drive selected with all motors off");
  chk_dma_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(dma_path_ok) |-> (!dma_wr_strobe && !host_data_oe))
    else $error("strobe honoured with dma path off");
  chk_wr_under_ack: assert property (@(posedge aclk) disable iff (!aresetn)
    dma_wr_strobe |-> ($past(ack_active) && !$past(wr_n) && dma_wr_byte == $past(host_data_in)))
    else $error("write strobe without acknowledge");
  chk_rate_reg_write: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(do_write) && $past(wlane_q) && ($past(awaddr_q) == OFS_CONFIG_CONTROL ||
     $past(awaddr_q) == OFS_DATA_RATE_SELECT)) |-> (rate == $past(wbyte_q[1:0])))
    else $error("rate not taken from last rate write");
  chk_reset_channel: assert property (@(posedge aclk)
    (!$past(aresetn) && aresetn) |-> (dma_request_oe == RST_DMA_OE && dma_request == '0))
    else $error("reset dma channel assignment wrong");
endmodule : fdco_top

// file: tb/fdco_dma_model.sv
// dma controller model on the far side of the drive control block
`timescale 1ns/1ps
module fdco_dma_model (
  input wire logic aclk,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  output logic [3:0] dma_ack_n = 4'hF,
  output logic rd_n = 1'b1,
  output logic wr_n = 1'b1,
  output logic [7:0] host_data_in = 8'h5A
);
  // one byte: acknowledge, strobe for three cycles, release
  task automatic xfer(input logic wr, input int ch, input logic [7:0] b, output logic [8:0] got);
    @(posedge aclk);
    dma_ack_n <= ~(4'h1 << ch);
    @(posedge aclk);
    wr_n <= !wr;
    rd_n <= wr;
    host_data_in <= wr ? b : host_data_in;
    repeat (3) @(posedge aclk);
    got = {host_data_oe, host_data_out};
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    host_data_in <= ~host_data_in; // released bus shows the inverse
    @(posedge aclk);
    dma_ack_n <= 4'hF;
  endtask : xfer
endmodule : fdco_dma_model

// file: tb/tb_fdco_top.sv
// self-checking bench for the floppy drive control outputs
`timescale 1ns/1ps
module tb_fdco_top;
  import fdco_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00, fdc_rd_byte = 8'h1E;
  logic [2:0] s_axil_awprot = 3'h0, s_axil_arprot = 3'h0;
  logic [31:0] s_axil_wdata = 32'h0;
  logic [3:0] s_axil_wstrb = 4'hF;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0, s_axil_arvalid = 1'b0;
  logic s_axil_rready = 1'b0, ident = 1'b0, seek_active = 1'b0, seek_step_in = 1'b0;
  logic rw_active = 1'b0, fdc_dma_req = 1'b0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, dma_wr_strobe;
  logic dma_rd_strobe, host_data_oe, density_select, head_dir_n, drive_select_0_n, drive_select_1_n;
  logic density_select_ppm, head_dir_ppm_n, rd_n, wr_n;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [31:0] s_axil_rdata, rv;
  logic [7:0] dma_wr_byte, host_data_in, host_data_out;
  logic [3:0] dma_ack_n, dma_request, dma_request_oe;
  logic [8:0] got;
  logic [7:0] rst_v [7] = '{RST_DIGITAL_OUTPUT, RST_FUNCTION_ENABLE, RST_FUNCTION_CONTROL,
    {6'h0, RST_RATE}, {6'h0, RST_RATE}, RST_MODE, 8'h3E};
  int n_fail = 0;
  int n_checks = 0;
  int n_wr = 0;
  int n_rd = 0;
  // 200 MHz clock
  always #2.5 aclk = ~aclk;
  fdco_top fdco_top_i (.*);
  fdco_dma_model fdco_dma_model_i (.aclk, .host_data_out, .host_data_oe, .dma_ack_n, .rd_n, .wr_n, .host_data_in);
  // count one-cycle dma strobes
  always @(posedge aclk) begin
    n_wr += (dma_wr_strobe === 1'b1);
    n_rd += (dma_rd_strobe === 1'b1);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // axi4-lite write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axil_awaddr <= a;
    s_axil_wdata <= {24'h0, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axil_awready === 1'b1) ad = 1'b1;
      if (s_axil_wready === 1'b1) wd = 1'b1;
      s_axil_awvalid <= !ad;
      s_axil_wvalid <= !wd;
    end
    do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
    chk("bresp", {30'h0, s_axil_bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : axw
  // axi4-lite read
  task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (s_axil_arready !== 1'b1);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b0;
    d = s_axil_rdata;
    chk("rresp", {30'h0, s_axil_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : axr
  // expected {sel1_n, sel0_n} for encoding, swap, select and motor
  function automatic logic [31:0] exp_ds(input logic e, input logic sw, input logic [1:0] s, input logic on);
    logic [1:0] p;
    p = (sw && !s[1]) ? {1'b0, ~s[0]} : s;
    if (!on) return 32'h3;
    if (e) return {30'h0, ~p};
    return (p == 2'd0) ? 32'h2 : ((p == 2'd1) ? 32'h1 : 32'h3);
  endfunction : exp_ds
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge aclk);
    n_fail++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("req_oe", {28'h0, dma_request_oe}, 32'h4);
    chk("sel rst", {drive_select_1_n, drive_select_0_n}, 32'h3);
    for (int i = 0; i < 7; i++) begin
      axr(8'(4 * i), RESP_OKAY, rv);
      chk("reset value", rv, {24'h0, rst_v[i]});
    end
    axr(8'h1C, RESP_SLVERR, rv);
    chk("unmapped", rv, 32'h0);
    axw(8'h1C, 8'hFF, RESP_SLVERR);
    // every rate code under both ident levels, via either rate register
    for (int i = 0; i < 8; i++) begin
      ident <= i[2];
      axw((i[0] ^ i[1]) ? OFS_CONFIG_CONTROL : OFS_DATA_RATE_SELECT, 8'(i % 4));
      axr((i[0] ^ i[1]) ? OFS_DATA_RATE_SELECT : OFS_CONFIG_CONTROL, RESP_OKAY, rv);
      chk("rate", rv, 32'(i % 4));
      chk("density", {31'h0, density_select}, 32'((i % 4 == 0 || i % 4 == 3) == i[2]));
    end
    // forced level beats the rate in both directions
    axw(OFS_MODE, 8'h21);
    chk("forced low", {31'h0, density_select}, 32'h0);
    axw(OFS_MODE, 8'h23);
    axw(OFS_DATA_RATE_SELECT, 8'h02);
    chk("forced high", {31'h0, density_select}, 32'h1);
    // head direction and the ppm copies
    axw(OFS_MODE, 8'h27);
    seek_active <= 1'b1;
    seek_step_in <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("dir in", {29'h0, head_dir_ppm_n, head_dir_n, density_select_ppm}, 32'h1);
    seek_step_in <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("dir out", {31'h0, head_dir_n}, 32'h1);
    seek_step_in <= 1'b1;
    rw_active <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("dir rw", {30'h0, head_dir_ppm_n, head_dir_n}, 32'h3);
    rw_active <= 1'b0;
    axw(OFS_MODE, 8'h2F);
    chk("ppm off", {29'h0, head_dir_ppm_n, head_dir_n, density_select_ppm}, 32'h4);
    axw(OFS_MODE, RST_MODE);
    // drive selects: encoding, swap, select, own or other motors
    for (int k = 0; k < 32; k++) begin
      if (k % 8 == 0) begin
        axw(OFS_FUNCTION_ENABLE, {3'h0, k[4], 4'h8});
        axw(OFS_FUNCTION_CONTROL, {3'h0, k[3], 4'h0});
      end
      axw(OFS_DIGITAL_OUTPUT, {k[0] ? 4'h1 << k[2:1] : ~(4'h1 << k[2:1]), 2'h0, k[2:1]});
      chk("drive sel", {30'h0, drive_select_1_n, drive_select_0_n}, exp_ds(k[4], k[3], k[2:1], k[0]));
    end
    axw(OFS_FUNCTION_ENABLE, RST_FUNCTION_ENABLE);
    axw(OFS_FUNCTION_CONTROL, RST_FUNCTION_CONTROL);
    // dma on channel two, then acknowledges that must be ignored
    axw(OFS_DIGITAL_OUTPUT, 8'h08);
    fdc_dma_req <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("request", {28'h0, dma_request}, 32'h4);
    fdco_dma_model_i.xfer(1'b1, 2, 8'hC1, got);
    fdco_dma_model_i.xfer(1'b0, 2, 8'h00, got);
    repeat (2) @(posedge aclk);
    chk("read bus", {23'h0, got}, 32'h11E);
    chk("write byte", {24'h0, dma_wr_byte}, 32'hC1);
    chk("strobes", 32'(n_wr * 16 + n_rd), 32'h11);
    fdco_dma_model_i.xfer(1'b1, 1, 8'h55, got);
    axw(OFS_MODE, 8'h60);
    fdco_dma_model_i.xfer(1'b1, 2, 8'h55, got);
    axw(OFS_MODE, RST_MODE);
    axw(OFS_FUNCTION_ENABLE, 8'h00);
    fdco_dma_model_i.xfer(1'b1, 2, 8'h55, got);
    repeat (2) @(posedge aclk);
    chk("ignored ack", 32'(n_wr), 32'h1);
    chk("held byte", {24'h0, dma_wr_byte}, 32'hC1);
    complete_run();
  end
endmodule : tb_fdco_top
